// file: design/stack_monitor_regs.svh
// Constants for the stack monitor command link, both ends
`ifndef STACK_MONITOR_REGS_SVH
`define STACK_MONITOR_REGS_SVH

// Whole command codes
`define WRITE_CONFIG_CMD 8'h01
`define READ_CONFIG_CMD 8'h02
`define READ_CELL_VOLTS_CMD 8'h04
`define READ_FLAGS_CMD 8'h06
`define READ_TEMPS_CMD 8'h08
`define POLL_CONV_STATUS_CMD 8'h40
`define POLL_IRQ_STATUS_CMD 8'h50

// Upper nibbles of the conversion families
`define START_CELL_CONV_CMD 4'h1
`define START_OPENWIRE_CONV_CMD 4'h2
`define START_TEMP_CONV_CMD 4'h3
`define START_CELL_CONV_DISCHARGE_CMD 4'h6
`define START_OPENWIRE_CONV_DISCHARGE_CMD 4'h7

// Lower nibble meanings
`define SEL_CELL11 4'hB
`define SEL_CELL12 4'hC
`define SEL_UNUSED 4'hD
`define SEL_SELF_TEST1 4'hE
`define SEL_SELF_TEST2 4'hF
`define SEL_TEMP_LAST 4'h3
`define SELF_TEST1_VALUE 12'h555
`define SELF_TEST2_VALUE 12'hAAA

// Group lengths in bytes
`define CFG_BYTES 5'd6
`define CV_BYTES 5'd18
`define CV_BYTES_TEN 5'd15
`define FLG_BYTES 5'd3
`define TMP_BYTES 5'd5

// Configuration byte 0 fields
`define CFG0_WATCHDOG 7
`define CFG0_GPIO_TWO 6
`define CFG0_GPIO_ONE 5
`define CFG0_LEVEL_POLL 4
`define CFG0_TEN_CELL 3
`define CFG0_DUTY_MSB 2
`define CFG0_RESET 8'h60
`define CFG_OTHER_RESET 8'h00

// CRC generator x^8+x^2+x+1 without the top term
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

// Timing
`define CLK_PERIOD_NS 40
`define LINK_PERIOD_NS 320
`define LINK_HALF_CYC (`LINK_PERIOD_NS / `CLK_PERIOD_NS / 2)
`define TOGGLE_HALF_US 500
`define TOGGLE_HALF_CYC (`TOGGLE_HALF_US * 1000 / `CLK_PERIOD_NS)

// Host register map
`define HOST_CMD_ADDR 8'h00
`define HOST_STATUS_ADDR 8'h04
`define HOST_STOP_ADDR 8'h08
`define HOST_BUF_BASE 2'b01

`endif

// file: design/stack_monitor_pkg.sv
// Types for the two ends of the stack monitor link
package stack_monitor_pkg;
	// Which conversion a start command asks for
	typedef enum logic [1:0] {conv_cell, conv_openwire, conv_temp} conv_family_t;
	// Which group a read returns
	typedef enum logic [1:0] {grp_cfg, grp_cv, grp_flg, grp_tmp} rd_group_t;
	// Host link sequencer
	typedef enum logic [2:0] {
		h_idle, h_lead, h_low, h_high, h_tail, h_hold
	} host_state_t;
endpackage

// file: design/stack_link_if.sv
// Serial link between host and stack monitor
`timescale 1ns/100ps
interface stack_link_if;
	logic chip_select_n; // Active-low select, host driven
	logic sck; // Serial clock, idles high
	logic sdi; // Host to device data
	logic sdo; // Device to host data
	modport device (input chip_select_n, input sck, input sdi, output sdo);
	modport host (output chip_select_n, output sck, output sdi, input sdo);
endinterface

// file: design/crc8_step.sv
// One serial step of the packet error code CRC
`timescale 1ns/100ps
`include "stack_monitor_regs.svh"
module crc8_step (
	input wire logic [7:0] crc_in, // Running value
	input wire logic bit_in, // Next data bit
	output logic [7:0] crc_out // Updated value
);
	logic fb; // Feedback term
	// Shift left, fold polynomial when feedback set
	always_comb begin
		fb = crc_in[7] ^ bit_in;
		crc_out = {crc_in[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
	end
endmodule

// file: design/monitor_device.sv
// Stack monitor end: command decoder, register groups, serial port
`timescale 1ns/100ps
`include "stack_monitor_regs.svh"
module monitor_device #(
	parameter int TOGGLE_HALF = `TOGGLE_HALF_CYC, // Poll toggle half period
	parameter logic [7:0] PEC_INIT = `CRC_INIT // CRC start value
) (
	input wire logic clk_in, // System clock
	input wire logic srst_in, // Sync reset, high
	stack_link_if.device link, // Serial link
	input wire logic result_wr_in, // Load one result
	input wire logic [3:0] result_idx_in, // 0-11 cells, 12-14 temps
	input wire logic [11:0] result_val_in, // Result value
	input wire logic [23:0] flag_bytes_in, // Flag group, byte 0 low
	input wire logic [3:0] temp_status_in, // Upper nibble temp byte 4
	input wire logic adc_busy_in, // Conversion running
	input wire logic ov_uv_irq_in, // Voltage fault present
	output logic conv_start_out, // Start pulse
	output stack_monitor_pkg::conv_family_t conv_family_out, // Kind
	output logic [3:0] conv_select_out, // 0 all, else input N
	output logic discharge_ok_out, // Discharge permitted
	output logic config_load_out, // Config committed pulse
	output logic [47:0] config_out // Config bytes, byte 0 low
);
	localparam int TW = $clog2(TOGGLE_HALF + 1); // Toggle counter width

	logic [2:0] sck_s, cs_s; // Synchronisers plus edge stage
	logic [1:0] sdi_s; // Data synchroniser
	logic sck_rise, sck_fall, cs_act, cs_rise; // Link events
	logic [2:0] rx_cnt_r; // Received bit count
	logic [7:0] rx_sh_r; // Receive shifter
	logic [7:0] rx_byte; // Byte just completed
	logic byte_done, cmd_go; // Byte and command strobes
	logic cmd_seen_r; // Command byte taken
	logic wr_mode_r; // Config write in progress
	logic [2:0] wr_cnt_r; // Data bytes taken
	logic [7:0] wbuf_r [6]; // Pending config bytes
	logic [7:0] cfg_r [6]; // Configuration group
	logic [11:0] res_r [15]; // Cell and temp results
	logic rd_mode_r; // Group read in progress
	stack_monitor_pkg::rd_group_t rd_group_r; // Group being read
	logic [7:0] tx_sh_r; // Transmit shifter
	logic [2:0] tx_cnt_r; // Transmitted bit count
	logic [4:0] tx_idx_r; // Next byte to load
	logic [7:0] crc_r, crc_nxt; // Packet error code
	logic poll_r, poll_irq_r; // Polling and its kind
	logic [TW-1:0] tog_cnt_r; // Toggle divider
	logic toggle_r; // Idle toggle level
	logic sdo_r; // Serial out flop
	logic ten_cell; // Ten-cell mode bit
	// Decoder outputs
	logic d_wr, d_rd, d_poll, d_pirq, d_start, d_dis, d_test, d_ttemp;
	logic [11:0] d_pat; // Self-test pattern
	stack_monitor_pkg::rd_group_t d_group;
	stack_monitor_pkg::conv_family_t d_fam;
	logic [3:0] hi, lo; // Command nibbles
	// Read byte source
	stack_monitor_pkg::rd_group_t g_sel;
	logic [4:0] b_sel, g_len;
	logic [7:0] g_byte;

	// Pack two 12-bit values into three bytes
	function automatic logic [7:0] pack3(input logic [11:0] a,
			input logic [11:0] b, input int r);
		if (r == 0) begin
			return a[7:0];
		end else if (r == 1) begin
			return {b[3:0], a[11:8]};
		end
		return b[11:4];
	endfunction

	// Synchronise link pins, keep one stage for edges
	always_ff @(posedge clk_in) begin
		sck_s <= {sck_s[1:0], link.sck};
		cs_s <= {cs_s[1:0], link.chip_select_n};
		sdi_s <= {sdi_s[0], link.sdi};
	end

	assign sck_rise = sck_s[1] & ~sck_s[2];
	assign sck_fall = ~sck_s[1] & sck_s[2];
	assign cs_act = ~cs_s[1];
	assign cs_rise = cs_s[1] & ~cs_s[2];
	assign rx_byte = {rx_sh_r[6:0], sdi_s[1]};
	assign byte_done = sck_rise & cs_act & ~poll_r & (rx_cnt_r == 3'd7);
	assign cmd_go = byte_done & ~cmd_seen_r;
	assign ten_cell = cfg_r[0][`CFG0_TEN_CELL];

	// Receive shifter, MSB first, sampled on rising clock
	always_ff @(posedge clk_in) begin
		if (srst_in || !cs_act) begin
			rx_cnt_r <= 3'd0;
			rx_sh_r <= 8'h00;
			cmd_seen_r <= 1'b0;
		end else if (sck_rise && !poll_r) begin
			rx_sh_r <= rx_byte;
			rx_cnt_r <= rx_cnt_r + 3'd1;
			if (rx_cnt_r == 3'd7) begin
				cmd_seen_r <= 1'b1;
			end
		end
	end

	// Command decoder
	always_comb begin
		hi = rx_byte[7:4];
		lo = rx_byte[3:0];
		d_wr = 1'b0;
		d_rd = 1'b0;
		d_group = stack_monitor_pkg::grp_cfg;
		d_poll = 1'b0;
		d_pirq = 1'b0;
		d_start = 1'b0;
		d_fam = stack_monitor_pkg::conv_cell;
		d_dis = hi[2];
		d_test = 1'b0;
		d_ttemp = 1'b0;
		d_pat = lo[0] ? `SELF_TEST2_VALUE : `SELF_TEST1_VALUE;
		if (rx_byte == `WRITE_CONFIG_CMD) begin
			d_wr = 1'b1;
		end else if (rx_byte == `READ_CONFIG_CMD) begin
			d_rd = 1'b1;
		end else if (rx_byte == `READ_CELL_VOLTS_CMD) begin
			d_rd = 1'b1;
			d_group = stack_monitor_pkg::grp_cv;
		end else if (rx_byte == `READ_FLAGS_CMD) begin
			d_rd = 1'b1;
			d_group = stack_monitor_pkg::grp_flg;
		end else if (rx_byte == `READ_TEMPS_CMD) begin
			d_rd = 1'b1;
			d_group = stack_monitor_pkg::grp_tmp;
		end else if (rx_byte == `POLL_CONV_STATUS_CMD) begin
			d_poll = 1'b1;
		end else if (rx_byte == `POLL_IRQ_STATUS_CMD) begin
			d_poll = 1'b1;
			d_pirq = 1'b1;
		end else if (hi == `START_CELL_CONV_CMD ||
				hi == `START_OPENWIRE_CONV_CMD ||
				hi == `START_CELL_CONV_DISCHARGE_CMD ||
				hi == `START_OPENWIRE_CONV_DISCHARGE_CMD) begin
			// Cell and open-wire families share nibble meaning
			if (hi == `START_OPENWIRE_CONV_CMD ||
					hi == `START_OPENWIRE_CONV_DISCHARGE_CMD) begin
				d_fam = stack_monitor_pkg::conv_openwire;
			end
			if (lo == `SEL_SELF_TEST1 || lo == `SEL_SELF_TEST2) begin
				d_test = 1'b1;
				d_poll = 1'b1;
			end else if (lo == `SEL_UNUSED) begin
				d_poll = 1'b0;
			end else if ((lo == `SEL_CELL11 || lo == `SEL_CELL12) &&
					ten_cell) begin
				d_poll = 1'b0;
			end else begin
				d_start = 1'b1;
				d_poll = 1'b1;
			end
		end else if (hi == `START_TEMP_CONV_CMD) begin
			d_fam = stack_monitor_pkg::conv_temp;
			if (lo <= `SEL_TEMP_LAST) begin
				d_start = 1'b1;
				d_poll = 1'b1;
			end else if (lo == `SEL_SELF_TEST1 ||
					lo == `SEL_SELF_TEST2) begin
				d_test = 1'b1;
				d_ttemp = 1'b1;
				d_poll = 1'b1;
			end
		end
	end

	// Conversion request outputs
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			conv_start_out <= 1'b0;
			conv_family_out <= stack_monitor_pkg::conv_cell;
			conv_select_out <= 4'h0;
			discharge_ok_out <= 1'b0;
		end else begin
			conv_start_out <= cmd_go & d_start;
			if (cmd_go && d_start) begin
				conv_family_out <= d_fam;
				conv_select_out <= lo;
				discharge_ok_out <= d_dis &
					(d_fam != stack_monitor_pkg::conv_temp);
			end
		end
	end

	// Result store; self test overwrites a whole family
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 15; i++) begin
			if (srst_in) begin
				res_r[i] <= 12'h000;
			end else if (cmd_go && d_test && ((i >= 12) == d_ttemp)) begin
				res_r[i] <= d_pat;
			end else if (result_wr_in && result_idx_in == 4'(i)) begin
				res_r[i] <= result_val_in;
			end
		end
	end

	// Config write: buffer data bytes, commit at select release
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_mode_r <= 1'b0;
			wr_cnt_r <= 3'd0;
			config_load_out <= 1'b0;
			cfg_r[0] <= `CFG0_RESET;
			for (int i = 0; i < 6; i++) begin
				wbuf_r[i] <= `CFG_OTHER_RESET;
				if (i > 0) begin
					cfg_r[i] <= `CFG_OTHER_RESET;
				end
			end
		end else begin
			config_load_out <= 1'b0;
			if (cs_rise && wr_mode_r && wr_cnt_r == 3'(`CFG_BYTES)) begin
				for (int i = 0; i < 6; i++) begin
					cfg_r[i] <= wbuf_r[i];
				end
				config_load_out <= 1'b1;
			end
			if (!cs_act) begin
				wr_mode_r <= 1'b0;
				wr_cnt_r <= 3'd0;
			end else if (cmd_go) begin
				wr_mode_r <= d_wr;
			end else if (byte_done && wr_mode_r &&
					wr_cnt_r < 3'(`CFG_BYTES)) begin
				wbuf_r[wr_cnt_r] <= rx_byte;
				wr_cnt_r <= wr_cnt_r + 3'd1;
			end
		end
	end

	// Byte source for reads
	always_comb begin
		int p;
		int r;
		p = 0;
		r = 0;
		g_sel = cmd_go ? d_group : rd_group_r;
		b_sel = cmd_go ? 5'd0 : tx_idx_r;
		p = int'(b_sel) / 3;
		r = int'(b_sel) % 3;
		if (p > 5) begin
			p = 5;
		end
		g_byte = 8'h00;
		g_len = `CFG_BYTES;
		case (g_sel)
			stack_monitor_pkg::grp_cfg: begin
				if (b_sel < `CFG_BYTES) begin
					g_byte = cfg_r[b_sel[2:0]];
				end
			end
			stack_monitor_pkg::grp_cv: begin
				g_len = ten_cell ? `CV_BYTES_TEN : `CV_BYTES;
				g_byte = pack3(res_r[2 * p], res_r[2 * p + 1], r);
			end
			stack_monitor_pkg::grp_flg: begin
				g_len = `FLG_BYTES;
				if (b_sel < `FLG_BYTES) begin
					g_byte = flag_bytes_in[8 * b_sel[1:0] +: 8];
				end
				if (b_sel == 5'd2 && ten_cell) begin
					g_byte[7:4] = 4'h0; // Cells 11, 12 flags held low
				end
			end
			default: begin
				g_len = `TMP_BYTES;
				if (b_sel < 5'd3) begin
					g_byte = pack3(res_r[12], res_r[13], r);
				end else if (b_sel == 5'd3) begin
					g_byte = res_r[14][7:0];
				end else begin
					g_byte = {temp_status_in, res_r[14][11:8]};
				end
			end
		endcase
	end

	crc8_step u_crc (
		.crc_in(crc_r),
		.bit_in(tx_sh_r[7]),
		.crc_out(crc_nxt)
	);

	// Read shifter: bit changes on falling clock, then CRC, then zeros
	always_ff @(posedge clk_in) begin
		if (srst_in || !cs_act) begin
			rd_mode_r <= 1'b0;
			rd_group_r <= stack_monitor_pkg::grp_cfg;
			tx_sh_r <= 8'h00;
			tx_cnt_r <= 3'd0;
			tx_idx_r <= 5'd0;
			crc_r <= PEC_INIT;
		end else if (cmd_go) begin
			rd_mode_r <= d_rd;
			rd_group_r <= d_group;
			tx_sh_r <= g_byte;
			tx_cnt_r <= 3'd0;
			tx_idx_r <= 5'd1;
			crc_r <= PEC_INIT;
		end else if (sck_fall && rd_mode_r) begin
			tx_cnt_r <= tx_cnt_r + 3'd1;
			if (tx_idx_r <= g_len) begin
				crc_r <= crc_nxt;
			end
			if (tx_cnt_r != 3'd7) begin
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			end else if (tx_idx_r < g_len) begin
				tx_sh_r <= g_byte;
			end else if (tx_idx_r == g_len) begin
				tx_sh_r <= crc_nxt;
			end else begin
				tx_sh_r <= 8'h00;
			end
			if (tx_cnt_r == 3'd7 && tx_idx_r <= g_len) begin
				tx_idx_r <= tx_idx_r + 5'd1;
			end
		end
	end

	// Polling mode, left when select goes high
	always_ff @(posedge clk_in) begin
		if (srst_in || !cs_act) begin
			poll_r <= 1'b0;
			poll_irq_r <= 1'b0;
		end else if (cmd_go && d_poll) begin
			poll_r <= 1'b1;
			poll_irq_r <= d_pirq;
		end
	end

	// Free running toggle for toggle polling
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tog_cnt_r <= '0;
			toggle_r <= 1'b1;
		end else if (tog_cnt_r == TW'(TOGGLE_HALF - 1)) begin
			tog_cnt_r <= '0;
			toggle_r <= ~toggle_r;
		end else begin
			tog_cnt_r <= tog_cnt_r + 1'b1;
		end
	end

	// Serial output: poll state, read bits, high while deselected, else held
	always_ff @(posedge clk_in) begin
		if (srst_in || !cs_act) begin
			sdo_r <= 1'b1;
		end else if (poll_r) begin
			if (poll_irq_r ? ov_uv_irq_in : adc_busy_in) begin
				sdo_r <= 1'b0;
			end else begin
				sdo_r <= cfg_r[0][`CFG0_LEVEL_POLL] | toggle_r;
			end
		end else if (sck_fall && rd_mode_r) begin
			sdo_r <= tx_sh_r[7];
		end
	end

	assign link.sdo = sdo_r;
	assign config_out = {cfg_r[5], cfg_r[4], cfg_r[3],
		cfg_r[2], cfg_r[1], cfg_r[0]};
endmodule

// file: design/monitor_host.sv
// Host end: register port driven command sequencer for the link
`timescale 1ns/100ps
`include "stack_monitor_regs.svh"
module monitor_host #(
	parameter int HALF = `LINK_HALF_CYC, // Link half period, cycles
	parameter int BUF_DEPTH = 32 // Data buffer bytes
) (
	input wire logic clk_in, // System clock
	input wire logic srst_in, // Sync reset, high
	stack_link_if.host link, // Serial link
	input wire logic [7:0] addr_in, // Register address
	input wire logic [15:0] wdata_in, // Write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	output logic [15:0] rdata_out // Read data, cycle after strobe
);
	localparam int DW = $clog2(HALF + 1); // Divider width

	stack_monitor_pkg::host_state_t st_r; // Sequencer state
	logic [DW-1:0] div_r; // Half period counter
	logic tick; // Half period over
	logic [7:0] buf_r [BUF_DEPTH]; // Send and receive buffer
	logic [4:0] nbytes_r; // Data bytes after command
	logic hold_r; // Keep select low after bytes
	logic [2:0] bit_r; // Bit in byte
	logic [4:0] byte_r; // 0 command, then data
	logic [7:0] tx_sh_r, rx_sh_r; // Shifters
	logic cs_n_r, sck_r, sdi_r; // Pin flops
	logic [1:0] sdo_s; // Input synchroniser
	logic start, stop; // Register commands

	assign tick = (div_r == DW'(HALF - 1));
	assign start = wr_in && addr_in == `HOST_CMD_ADDR &&
		st_r == stack_monitor_pkg::h_idle;
	assign stop = wr_in && addr_in == `HOST_STOP_ADDR;

	// Sample the device output
	always_ff @(posedge clk_in) begin
		sdo_s <= {sdo_s[0], link.sdo};
	end

	// Half period divider, restarted on each phase
	always_ff @(posedge clk_in) begin
		if (srst_in || st_r == stack_monitor_pkg::h_idle || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// Link sequencer
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_r <= stack_monitor_pkg::h_idle;
			cs_n_r <= 1'b1;
			sck_r <= 1'b1;
			sdi_r <= 1'b1;
			bit_r <= 3'd0;
			byte_r <= 5'd0;
			tx_sh_r <= 8'h00;
			rx_sh_r <= 8'h00;
			nbytes_r <= 5'd0;
			hold_r <= 1'b0;
		end else begin
			case (st_r)
				stack_monitor_pkg::h_idle: begin
					if (start) begin
						tx_sh_r <= wdata_in[7:0];
						nbytes_r <= wdata_in[12:8];
						hold_r <= wdata_in[13];
						bit_r <= 3'd0;
						byte_r <= 5'd0;
						cs_n_r <= 1'b0;
						st_r <= stack_monitor_pkg::h_lead;
					end
				end
				stack_monitor_pkg::h_lead: begin
					if (tick) begin
						st_r <= stack_monitor_pkg::h_low;
						sck_r <= 1'b0;
						sdi_r <= tx_sh_r[7];
					end
				end
				stack_monitor_pkg::h_low: begin
					if (tick) begin
						sck_r <= 1'b1;
						st_r <= stack_monitor_pkg::h_high;
					end
				end
				stack_monitor_pkg::h_high: begin
					if (tick) begin
						rx_sh_r <= {rx_sh_r[6:0], sdo_s[1]};
						bit_r <= bit_r + 3'd1;
						tx_sh_r <= {tx_sh_r[6:0], 1'b0};
						if (bit_r == 3'd7 && byte_r == nbytes_r) begin
							st_r <= hold_r ? stack_monitor_pkg::h_hold :
								stack_monitor_pkg::h_tail;
						end else begin
							if (bit_r == 3'd7) begin
								byte_r <= byte_r + 5'd1;
								tx_sh_r <= buf_r[byte_r];
							end
							sck_r <= 1'b0;
							sdi_r <= (bit_r == 3'd7) ? buf_r[byte_r][7] :
								tx_sh_r[6];
							st_r <= stack_monitor_pkg::h_low;
						end
					end
				end
				stack_monitor_pkg::h_tail: begin
					if (tick) begin
						cs_n_r <= 1'b1;
						st_r <= stack_monitor_pkg::h_idle;
					end
				end
				default: begin
					if (stop) begin
						cs_n_r <= 1'b1;
						st_r <= stack_monitor_pkg::h_idle;
					end
				end
			endcase
		end
	end

	// Buffer: bus writes, and bytes received after the command
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < BUF_DEPTH; i++) begin
			if (srst_in) begin
				buf_r[i] <= 8'h00;
			end else if (st_r == stack_monitor_pkg::h_high && tick &&
					bit_r == 3'd7 && byte_r != 5'd0 &&
					byte_r == 5'(i + 1)) begin
				buf_r[i] <= {rx_sh_r[6:0], sdo_s[1]};
			end else if (wr_in && addr_in[7:6] == `HOST_BUF_BASE &&
					addr_in[4:0] == 5'(i)) begin
				buf_r[i] <= wdata_in[7:0];
			end
		end
	end

	// Register reads, zero for unmapped addresses
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_out <= 16'h0000;
		end else if (rd_in) begin
			if (addr_in == `HOST_STATUS_ADDR) begin
				rdata_out <= {14'h0000, sdo_s[1],
					st_r != stack_monitor_pkg::h_idle};
			end else if (addr_in[7:6] == `HOST_BUF_BASE &&
					addr_in[5] == 1'b0) begin
				rdata_out <= {8'h00, buf_r[addr_in[4:0]]};
			end else begin
				rdata_out <= 16'h0000;
			end
		end
	end

	assign link.chip_select_n = cs_n_r;
	assign link.sck = sck_r;
	assign link.sdi = sdi_r;
endmodule

// file: dv/stack_link_sva.sv
// Wire-level assertions on the host to monitor link
`timescale 1ns/100ps
module stack_link_sva (
	input wire logic clk_in, // System clock
	input wire logic srst_in, // Sync reset, high
	input wire logic chip_select_n, // Select, low active
	input wire logic sck, // Link clock
	input wire logic sdi, // Host data
	input wire logic sdo // Device data
);
	logic sck_r; // Link clock, last cycle
	logic [2:0] bits_r; // Rises in frame, modulo 8
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// Count link clock rises inside a frame
	always_ff @(posedge clk_in) begin
		sck_r <= sck;
		if (srst_in || chip_select_n)
			bits_r <= 3'h0;
		else if (sck && !sck_r)
			bits_r <= bits_r + 3'h1;
	end
	reset_idle_a: assert property ($fell(srst_in) |->
		chip_select_n && sck && sdi && sdo) else $error("link not idle");
	sck_idle_a: assert property (chip_select_n |-> sck)
		else $error("clock moved outside frame");
	sel_lead_a: assert property ($fell(chip_select_n) |-> sck[*4] ##1 !sck)
		else $error("bad select lead");
	low_phase_a: assert property ($fell(sck) |-> (!sck)[*4] ##1 sck)
		else $error("bad low phase");
	high_phase_a: assert property ($rose(sck) && !chip_select_n |-> sck[*4])
		else $error("bad high phase");
	sdi_hold_a: assert property (!chip_select_n && sck && $past(sck) |->
		$stable(sdi)) else $error("data moved while clock high");
	frame_bits_a: assert property ($rose(chip_select_n) |-> bits_r == 3'h0)
		else $error("frame not whole bytes");
	sel_gap_a: assert property ($rose(chip_select_n) |-> chip_select_n[*3])
		else $error("select gap short");
endmodule

// file: dv/test_stack_monitor_command_decoder.sv
// Bench joining host and monitor ends, with a reference model
`timescale 1ns/100ps
module test_stack_monitor_command_decoder;
	logic clk_in = 0; // Clock
	logic srst_in = 1; // Reset
	logic [7:0] addr = 0; // Register address
	logic [15:0] wdata = 0; // Write data
	logic [15:0] rdata; // Read data
	logic wr_s = 0; // Write strobe
	logic rd_s = 0; // Read strobe
	logic res_wr = 0; // Result load
	logic [3:0] res_idx = 0; // Result slot
	logic [11:0] res_val = 0; // Result value
	logic [23:0] flags = 0; // Flag bytes
	logic [3:0] tstat = 0; // Temp status
	logic busy = 0; // Converter busy
	logic irq = 0; // Voltage fault
	logic cs_p, dis, ld_p; // Pulses, discharge
	stack_monitor_pkg::conv_family_t fam; // Family
	logic [3:0] sel; // Select nibble
	logic [47:0] cfg_out; // Config bytes
	int miscompares = 0, check_count = 0, seed = 88, starts = 0, loads = 0;
	logic [11:0] res [15]; // Result model
	logic [7:0] cfg [6]; // Config model
	logic [7:0] q [$]; // Expected group
	logic [7:0] cl [11] = '{8'h10, 8'h1A, 8'h1B, 8'h1D, 8'h25, 8'h30, 8'h33,
		8'h34, 8'h6C, 8'h66, 8'h71}; // Codes tried
	logic [15:0] d; // Last read
	logic e; // Start expected
	stack_link_if link ();
	monitor_host #(.HALF(4)) u_monitor_host (.clk_in, .srst_in,
		.link(link.host), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
		.rd_in(rd_s), .rdata_out(rdata));
	monitor_device #(.TOGGLE_HALF(8)) u_monitor_device (.clk_in, .srst_in,
		.link(link.device), .result_wr_in(res_wr), .result_idx_in(res_idx),
		.result_val_in(res_val), .flag_bytes_in(flags),
		.temp_status_in(tstat), .adc_busy_in(busy), .ov_uv_irq_in(irq),
		.conv_start_out(cs_p), .conv_family_out(fam),
		.conv_select_out(sel), .discharge_ok_out(dis),
		.config_load_out(ld_p), .config_out(cfg_out));
	stack_link_sva u_stack_link_sva (.clk_in, .srst_in,
		.chip_select_n(link.chip_select_n), .sck(link.sck),
		.sdi(link.sdi), .sdo(link.sdo));
	// Clock
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	// Count device pulses
	always @(posedge clk_in) begin
		starts += cs_p;
		loads += ld_p;
	end
	// Compare and report
	task chk(input string n, input logic [47:0] s, input logic [47:0] x);
		check_count++;
		if (s !== x) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, x, s);
		end
	endtask
	task results();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Register port cycles
	task wr(input logic [7:0] a, input logic [15:0] v);
		addr <= a;
		wdata <= v;
		wr_s <= 1;
		@(posedge clk_in);
		wr_s <= 0;
		@(posedge clk_in);
	endtask
	task rd(input logic [7:0] a);
		addr <= a;
		rd_s <= 1;
		@(posedge clk_in);
		rd_s <= 0;
		#1 d = rdata;
		@(posedge clk_in);
	endtask
	// Send a command, wait for the host to finish
	task run(input logic [7:0] c, input logic [4:0] n);
		repeat (3) @(posedge clk_in);
		wr(8'h00, {3'b000, n, c});
		d = 1;
		for (int i = 0; i < 3000 && d[0] !== 1'b0; i++)
			rd(8'h04);
		if (d[0] !== 1'b0) begin
			miscompares++;
			results();
		end
		repeat (4) @(posedge clk_in);
	endtask
	task wait_sdo(input logic v);
		rd(8'h04);
		for (int i = 0; i < 400 && d[1] !== v; i++)
			rd(8'h04);
		chk("poll", d[1], v);
		if (d[1] !== v)
			results();
	endtask
	function automatic logic [7:0] crc(input logic [7:0] b [$]);
		logic [7:0] r;
		r = 0;
		foreach (b[i])
			for (int k = 7; k >= 0; k--)
				r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i][k]) ? 8'h07 : 8'h00);
		return r;
	endfunction
	// Read a group and compare with queue, CRC and pad
	task grp(input logic [7:0] c);
		run(c, 5'(q.size() + 2));
		q.push_back(crc(q));
		q.push_back(8'h00);
		foreach (q[i]) begin
			rd(8'(64 + i));
			chk("group", d[7:0], q[i]);
		end
		q = {};
	endtask
	task pack(input int a);
		q.push_back(res[a][7:0]);
		q.push_back({res[a + 1][3:0], res[a][11:8]});
		q.push_back(res[a + 1][11:4]);
	endtask
	task cfg_wr(input logic ten);
		cfg[0][3] = ten;
		cfg[0][4] = ten;
		for (int i = 0; i < 6; i++)
			wr(8'(64 + i), {8'h00, cfg[i]});
		run(8'h01, 5'd6);
		chk("cfg", cfg_out, {cfg[5], cfg[4], cfg[3], cfg[2], cfg[1], cfg[0]});
	endtask
	initial begin
		repeat (8) @(posedge clk_in);
		srst_in <= 0;
		@(posedge clk_in);
		for (int i = 0; i < 15; i++) begin
			res[i] = 12'($random(seed));
			res_idx <= 4'(i);
			res_val <= res[i];
			res_wr <= 1;
			@(posedge clk_in);
		end
		res_wr <= 0;
		flags <= 24'($random(seed));
		tstat <= 4'($random(seed));
		foreach (cfg[i])
			cfg[i] = 8'($random(seed));
		cfg_wr(0);
		chk("loads", loads, 1);
		foreach (cfg[i])
			q.push_back(cfg[i]);
		grp(8'h02);
		for (int c = 0; c < 12; c += 2)
			pack(c);
		grp(8'h04);
		for (int i = 0; i < 3; i++)
			q.push_back(flags[8 * i +: 8]);
		grp(8'h06);
		pack(12);
		q.push_back(res[14][7:0]);
		q.push_back({tstat, res[14][11:8]});
		grp(8'h08);
		$display("group reads done");
		cfg_wr(1);
		run(8'h1E, 5'd0);
		for (int c = 0; c < 12; c++)
			res[c] = 12'h555;
		for (int c = 0; c < 10; c += 2)
			pack(c);
		grp(8'h04);
		run(8'h3F, 5'd0);
		for (int c = 12; c < 15; c++)
			res[c] = 12'hAAA;
		pack(12);
		q.push_back(8'hAA);
		q.push_back({tstat, 4'hA});
		grp(8'h08);
		foreach (cl[i]) begin
			e = (cl[i][7:4] == 3) ? (cl[i][3:0] <= 3) :
				(cl[i][3:0] < 4'hB || (cl[i][3:0] < 4'hD && !cfg[0][3]));
			starts = 0;
			run(cl[i], 5'd0);
			rd(8'h04);
			chk("start", starts, e);
			if (e) begin
				chk("fam", fam, cl[i][7:4] == 3 ? stack_monitor_pkg::conv_temp :
					(cl[i][7:4] == 1 || cl[i][7:4] == 6) ?
					stack_monitor_pkg::conv_cell :
					stack_monitor_pkg::conv_openwire);
				chk("sel", sel, cl[i][3:0]);
				chk("dis", dis, cl[i][6]);
			end
		end
		$display("conversion codes done");
		busy <= 1;
		wr(8'h00, 16'h2040);
		wait_sdo(0);
		busy <= 0;
		wait_sdo(1);
		wr(8'h08, 16'h0000);
		run(8'h00, 5'd0);
		chk("noop", cfg_out,
			{cfg[5], cfg[4], cfg[3], cfg[2], cfg[1], cfg[0]});
		irq <= 1;
		wr(8'h00, 16'h2050);
		wait_sdo(0);
		irq <= 0;
		wait_sdo(1);
		wr(8'h08, 16'h0000);
		$display("polling done");
		results();
	end
endmodule
